// [rtl/esr_pkg.sv]
// constants of the speed regulation loop
package esr_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned SEC_CYC       = CLK_HZ;
    localparam int unsigned LOOP_MS       = 10;
    localparam int unsigned LOOP_CYC      = CLK_HZ / 1000 * LOOP_MS;
    localparam int unsigned TICKS_PER_SEC = 1000 / LOOP_MS;

    localparam int          NCFG      = 19;
    localparam logic [4:0]  IDX_ECU_TYPE   = 5'h00;
    localparam logic [4:0]  IDX_TX_MODE    = 5'h01;
    localparam logic [4:0]  IDX_FAULT_MASK = 5'h02;
    localparam logic [4:0]  IDX_LINK_TMO   = 5'h03;
    localparam logic [4:0]  IDX_LINK_TYPE  = 5'h04;
    localparam logic [4:0]  IDX_ZERO_SPD   = 5'h05;
    localparam logic [4:0]  IDX_FULL_SPD   = 5'h06;
    localparam logic [4:0]  IDX_IDLE_SPD   = 5'h07;
    localparam logic [4:0]  IDX_OFFSET     = 5'h08;
    localparam logic [4:0]  IDX_LOOP_DLY   = 5'h09;
    localparam logic [4:0]  IDX_LOOP_OPT   = 5'h0A;
    localparam logic [4:0]  IDX_RAMP       = 5'h0B;
    localparam logic [4:0]  IDX_GAIN_P     = 5'h0C;
    localparam logic [4:0]  IDX_GAIN_I     = 5'h0D;
    localparam logic [4:0]  IDX_DEAD_BAND  = 5'h0E;
    localparam logic [4:0]  IDX_QTY_SEL    = 5'h0F;
    localparam logic [4:0]  IDX_NOMINAL    = 5'h10;
    localparam logic [4:0]  IDX_SETPOINT   = 5'h11;
    localparam logic [4:0]  IDX_RATED      = 5'h12;
    localparam logic [4:0]  IDX_STATUS     = 5'h13;
    localparam logic [4:0]  IDX_CMD_PCT    = 5'h14;
    localparam logic [4:0]  IDX_SPEED      = 5'h15;
    localparam logic [4:0]  IDX_ECU_FLAGS  = 5'h16;

    localparam logic [15:0] RST_RAMP      = 16'h0064;
    localparam logic [15:0] RST_GAIN      = 16'h0064;
    localparam logic [15:0] PCT_FULL      = 16'h2710;
    localparam logic [15:0] GAIN_ONE      = 16'h03E8;
    localparam logic [8:0]  ECU_J1939     = 9'h001;
    localparam logic [8:0]  ECU_PROFILE   = 9'h12C;
    localparam logic [6:0]  TX_RX_ONLY    = 7'h00;
    localparam logic [6:0]  TX_ON_DEMAND  = 7'h01;
    localparam logic [6:0]  TX_CMD_LO     = 7'h02;
    localparam logic [6:0]  TX_CMD_HI     = 7'h5A;
    localparam logic [6:0]  TX_ALL_LO     = 7'h5B;
    localparam logic [6:0]  TX_ALL_HI     = 7'h63;
    localparam int          OPT_INVERT    = 0;
    localparam int          OPT_LOAD_ONLY = 1;
    localparam logic [3:0]  QTY_VOLTAGE   = 4'h0;
    localparam int          INTEG_LIM     = 10000;

    typedef enum logic [1:0] {
        ESR_HOLD,
        ESR_WAIT,
        ESR_RUN
    } esr_loop_t;

    function automatic logic [15:0] esr_rst(input int i);
        if (i == int'(IDX_RAMP))
            return RST_RAMP;
        else if (i == int'(IDX_GAIN_P) || i == int'(IDX_GAIN_I))
            return RST_GAIN;
        else
            return 16'h0000;
    endfunction
endpackage

// [rtl/esr_sec_count.sv]
// saturating count of whole seconds while enabled
module esr_sec_count #(
    parameter int unsigned CYC = esr_pkg::SEC_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clr,
    input  wire logic        en,
    output logic      [15:0] secs
);
    logic [31:0] div;
    wire         wrap = (div == CYC - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div <= 32'h0000_0000;
        else if (clr || !en || wrap)
            div <= 32'h0000_0000;
        else
            div <= div + 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            secs <= 16'h0000;
        else if (clr)
            secs <= 16'h0000;
        else if (en && wrap && secs != 16'hFFFF)
            secs <= secs + 16'h0001;
    end
endmodule

// [rtl/esr_speed_loop.sv]
// engine speed regulation loop
// Functional notes
// - generic j1939 ecu type selectable
// - type 300 selects loaded ecu profile
// - transmit mode gates what is sent
// - fault mask bits suppress ecu anomalies
// - link-loss alarm after silence, zero disables
// - bus-off alarm whenever ecu type nonzero
// - can state and ecu specific flags
// - percent command maps linearly to rpm
// - zero speed above full inverts mapping
// - offset while starting, delayed loop enable
// - option bit 1 needs loads connected
// - desired value ramps, 0 or 100% off
// - error polarity chosen by option bit 0
// - two gains, zero gains give offset only
// - no correction inside dead band
// - selector 0 regulates dc voltage
// - nominal zero uses rated voltage
// - desired from analogue, setpoint, else rated
// - speed request sent over can
// - idle cycle requests idle speed
module esr_speed_loop
    import esr_pkg::*;
#(
    parameter int unsigned SEC_CYCLES  = esr_pkg::SEC_CYC,
    parameter int unsigned LOOP_CYCLES = esr_pkg::LOOP_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ecu_rx_msg,
    input  wire logic        can_bus_off,
    input  wire logic        can_err_passive,
    input  wire logic        can_err_active,
    input  wire logic [15:0] ecu_specific_in,
    input  wire logic [15:0] ecu_fault_in,
    input  wire logic        engine_running,
    input  wire logic        engine_start_stop,
    input  wire logic        idle_cycle,
    input  wire logic        load_breaker,
    input  wire logic        clutch_engaged,
    input  wire logic [15:0] dc_voltage,
    input  wire logic [15:0] other_quantity,
    input  wire logic        analog_sp_valid,
    input  wire logic [15:0] analog_sp,
    output logic             link_loss_alarm,
    output logic      [3:0]  link_loss_type,
    output logic             bus_off_alarm,
    output logic             bus_off_flag,
    output logic             error_passive_flag,
    output logic             error_active_flag,
    output logic             active_no_rx_flag,
    output logic      [15:0] ecu_specific_flags,
    output logic      [15:0] ecu_anomaly,
    output logic             can_tx_enable,
    output logic             on_demand_enable,
    output logic             ecu_cmd_enable,
    output logic             speed_cmd_enable,
    output logic             j1939_generic,
    output logic             use_ecu_profile,
    output logic      [15:0] speed_request_rpm,
    output logic      [15:0] cmd_pct
);
    logic [15:0] cfg [NCFG];
    esr_loop_t   loop_state;
    logic [31:0] tick_cnt;
    logic        tick;
    logic [15:0] silent_secs;
    logic [15:0] run_secs;
    logic [17:0] ramp_val;
    logic signed [31:0] integ;

    // apb decode
    wire  [4:0] idx      = paddr[6:2];
    wire        acc      = psel && penable;
    wire        cfg_hit  = (paddr[7] == 1'b0) && (idx < 5'(NCFG));
    wire        ro_hit   = (paddr[7] == 1'b0) && (idx >= IDX_STATUS)
                           && (idx <= IDX_ECU_FLAGS);
    wire        bad_addr = !(cfg_hit || ro_hit) || (ro_hit && pwrite);
    wire        wr_en    = acc && pwrite && cfg_hit;

    wire [8:0]  ecu_type  = cfg[IDX_ECU_TYPE][8:0];
    wire [6:0]  tx_mode   = cfg[IDX_TX_MODE][6:0];
    wire [1:0]  loop_opt  = cfg[IDX_LOOP_OPT][1:0];
    wire [15:0] rated     = cfg[IDX_RATED];
    wire [15:0] ramp_rate = cfg[IDX_RAMP];

    wire [31:0] status_word = {24'h000000, 1'b0, speed_cmd_enable,
                               link_loss_alarm, bus_off_alarm,
                               active_no_rx_flag, error_active_flag,
                               error_passive_flag, bus_off_flag};

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (cfg_hit)
            prdata = {16'h0000, cfg[idx]};
        else if (idx == IDX_STATUS)
            prdata = status_word;
        else if (idx == IDX_CMD_PCT)
            prdata = {16'h0000, cmd_pct};
        else if (idx == IDX_SPEED)
            prdata = {16'h0000, speed_request_rpm};
        else if (idx == IDX_ECU_FLAGS)
            prdata = {16'h0000, ecu_specific_flags};
    end

    assign pready  = 1'b1;
    assign pslverr = acc && bad_addr;

    genvar gi;
    generate
        for (gi = 0; gi < NCFG; gi++)
        begin : g_cfg
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg[gi] <= esr_rst(gi);
                else if (wr_en && idx == 5'(gi))
                    cfg[gi] <= pwdata[15:0];
            end
        end
    endgenerate

    // ecu select, tx permissions
    assign j1939_generic    = (ecu_type == ECU_J1939);
    assign use_ecu_profile  = (ecu_type == ECU_PROFILE);
    assign can_tx_enable    = (ecu_type != 9'h000)
                              && (tx_mode != TX_RX_ONLY);
    assign on_demand_enable = can_tx_enable;
    assign ecu_cmd_enable   = can_tx_enable && (tx_mode >= TX_CMD_LO)
                              && (tx_mode <= TX_ALL_HI);
    assign speed_cmd_enable = can_tx_enable && (tx_mode >= TX_ALL_LO)
                              && (tx_mode <= TX_ALL_HI);

    // link supervision
    esr_sec_count #(
        .CYC (SEC_CYCLES)
    ) u_silent (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (ecu_rx_msg),
        .en      (1'b1),
        .secs    (silent_secs)
    );

    wire link_lost = (cfg[IDX_LINK_TMO] != 16'h0000)
                     && (silent_secs >= cfg[IDX_LINK_TMO]);
    wire no_rx     = (silent_secs != 16'h0000);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            link_loss_alarm    <= 1'b0;
            bus_off_alarm      <= 1'b0;
            bus_off_flag       <= 1'b0;
            error_passive_flag <= 1'b0;
            error_active_flag  <= 1'b0;
            active_no_rx_flag  <= 1'b0;
            ecu_specific_flags <= 16'h0000;
            ecu_anomaly        <= 16'h0000;
        end
        else
        begin
            link_loss_alarm    <= link_lost && !ecu_rx_msg;
            bus_off_alarm      <= (ecu_type != 9'h000) && can_bus_off;
            bus_off_flag       <= can_bus_off;
            error_passive_flag <= can_err_passive;
            error_active_flag  <= can_err_active;
            active_no_rx_flag  <= can_err_active && no_rx;
            ecu_specific_flags <= ecu_specific_in;
            ecu_anomaly        <= ecu_fault_in & ~cfg[IDX_FAULT_MASK];
        end
    end

    assign link_loss_type = cfg[IDX_LINK_TYPE][3:0];

    // loop enable timing
    esr_sec_count #(
        .CYC (SEC_CYCLES)
    ) u_run (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (!engine_running || engine_start_stop),
        .en      (1'b1),
        .secs    (run_secs)
    );

    wire loads_on  = load_breaker || clutch_engaged;
    wire delay_ok  = run_secs >= cfg[IDX_LOOP_DLY];
    wire run_ok    = engine_running && !engine_start_stop;
    wire load_ok   = !loop_opt[OPT_LOAD_ONLY] || loads_on;
    wire loop_go   = run_ok && delay_ok && load_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_cnt <= 32'h0000_0000;
        else if (tick)
            tick_cnt <= 32'h0000_0000;
        else
            tick_cnt <= tick_cnt + 32'h0000_0001;
    end

    assign tick = (tick_cnt == LOOP_CYCLES - 1);

    // quantity, nominal, desired
    wire [15:0] actual  = (cfg[IDX_QTY_SEL][3:0] == QTY_VOLTAGE)
                          ? dc_voltage : other_quantity;
    wire [15:0] nominal = (cfg[IDX_NOMINAL] != 16'h0000)
                          ? cfg[IDX_NOMINAL] : rated;
    wire [15:0] sp_reg  = (cfg[IDX_SETPOINT] != 16'h0000)
                          ? cfg[IDX_SETPOINT] : rated;
    wire [15:0] desired = analog_sp_valid ? analog_sp : sp_reg;

    // desired value ramp
    wire        ramp_off  = (ramp_rate == 16'h0000)
                            || (ramp_rate >= PCT_FULL);
    wire [31:0] step_raw  = (32'(rated) * 32'(ramp_rate))
                            / (32'(PCT_FULL) * TICKS_PER_SEC);
    wire [17:0] step      = (step_raw == 32'h0) ? 18'h00001
                            : (step_raw > 32'h0FFFF) ? 18'h0FFFF
                            : step_raw[17:0];
    wire [17:0] des18     = {2'b00, desired};
    wire [17:0] ramp_up   = ramp_val + step;
    wire [17:0] ramp_dn   = (ramp_val > step) ? ramp_val - step : 18'h0;
    wire [17:0] next_ramp = ramp_off ? des18
                            : (ramp_val < des18)
                              ? ((ramp_up > des18) ? des18 : ramp_up)
                              : ((ramp_dn < des18) ? des18 : ramp_dn);

    // error in 0.01% of nominal
    wire signed [31:0] err_q   = $signed({14'h0, ramp_val})
                                 - $signed({16'h0, actual});
    wire signed [31:0] err_s   = loop_opt[OPT_INVERT] ? -err_q : err_q;
    wire signed [47:0] err_big = 48'(err_s) * 48'sd10000;
    wire signed [47:0] err_div = (nominal == 16'h0000) ? 48'sd0
                                 : err_big / $signed({32'h0, nominal});
    wire signed [31:0] err_pct = (err_div > 48'sd1000000) ? 32'sd1000000
                                 : (err_div < -48'sd1000000) ? -32'sd1000000
                                 : err_div[31:0];
    wire        [31:0] err_abs = err_pct[31] ? 32'(-err_pct)
                                             : 32'(err_pct);
    wire        in_band = err_abs < 32'(cfg[IDX_DEAD_BAND]);

    // pi terms
    wire signed [47:0] p_full  = 48'(err_pct)
                                 * $signed({32'h0, cfg[IDX_GAIN_P]});
    wire signed [47:0] i_full  = 48'(err_pct)
                                 * $signed({32'h0, cfg[IDX_GAIN_I]});
    wire signed [47:0] p_term  = p_full / $signed({32'h0, GAIN_ONE});
    wire signed [47:0] i_step  = i_full
                                 / (48'sd1000 * $signed(48'(TICKS_PER_SEC)));
    wire signed [47:0] i_sum   = 48'(integ) + i_step;
    wire signed [31:0] next_integ = (i_sum > 48'(INTEG_LIM))
                                    ? 32'(INTEG_LIM)
                                    : (i_sum < -48'(INTEG_LIM))
                                      ? -32'(INTEG_LIM) : i_sum[31:0];
    wire signed [47:0] cmd_sum = $signed({32'h0, cfg[IDX_OFFSET]})
                                 + p_term + 48'(next_integ);
    wire        [15:0] next_cmd = (cmd_sum < 48'sd0) ? 16'h0000
                                  : (cmd_sum > 48'(PCT_FULL)) ? PCT_FULL
                                  : cmd_sum[15:0];

    wire [15:0] offset_cl = (cfg[IDX_OFFSET] > PCT_FULL)
                            ? PCT_FULL : cfg[IDX_OFFSET];

    // loop state machine
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            loop_state <= ESR_HOLD;
        else if (!loop_go)
            loop_state <= ESR_HOLD;
        else
        begin
            unique case (loop_state)
                ESR_HOLD: loop_state <= ESR_WAIT;
                ESR_WAIT: loop_state <= tick ? ESR_RUN : ESR_WAIT;
                ESR_RUN:  loop_state <= ESR_RUN;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_pct  <= 16'h0000;
            integ    <= 32'sd0;
            ramp_val <= 18'h00000;
        end
        else if (loop_state != ESR_RUN)
        begin
            cmd_pct  <= offset_cl;
            integ    <= 32'sd0;
            ramp_val <= ramp_off ? des18 : {2'b00, actual};
        end
        else if (tick)
        begin
            ramp_val <= next_ramp;
            if (!in_band)
            begin
                cmd_pct <= next_cmd;
                integ   <= next_integ;
            end
        end
    end

    // percent to rpm
    wire signed [17:0] spd_span = $signed({2'b00, cfg[IDX_FULL_SPD]})
                                  - $signed({2'b00, cfg[IDX_ZERO_SPD]});
    wire signed [35:0] spd_prod = 36'(spd_span)
                                  * $signed({20'h0, cmd_pct});
    wire signed [35:0] spd_off  = spd_prod / $signed({20'h0, PCT_FULL});
    wire signed [35:0] spd_sum  = $signed({20'h0, cfg[IDX_ZERO_SPD]})
                                  + spd_off;
    wire        [15:0] spd_map  = (spd_sum < 36'sd0) ? 16'h0000
                                  : spd_sum[15:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            speed_request_rpm <= 16'h0000;
        else if (idle_cycle)
            speed_request_rpm <= cfg[IDX_IDLE_SPD];
        else
            speed_request_rpm <= spd_map;
    end
endmodule

// [sim/esr_ecu_model.sv]
// engine ecu model on the can link
module esr_ecu_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        talk,
    input  wire logic [1:0]  can_state,
    input  wire logic        speed_cmd_enable,
    input  wire logic [15:0] speed_request_rpm,
    output logic             ecu_rx_msg,
    output logic             can_bus_off,
    output logic             can_err_passive,
    output logic             can_err_active,
    output logic      [15:0] last_rpm
);
    logic [4:0] gap;
    // a frame every 32 cycles while talking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap             <= 5'h00;
            ecu_rx_msg      <= 1'b0;
            can_bus_off     <= 1'b0;
            can_err_passive <= 1'b0;
            can_err_active  <= 1'b0;
            last_rpm        <= 16'h0000;
        end
        else
        begin
            gap             <= gap + 5'h01;
            ecu_rx_msg      <= talk && gap == 5'h1F;
            can_bus_off     <= can_state == 2'h2;
            can_err_passive <= can_state == 2'h1;
            can_err_active  <= can_state == 2'h0;
            if (speed_cmd_enable)
                last_rpm <= speed_request_rpm;
        end
    end
endmodule

// [sim/esr_speed_loop_checker.sv]
// assertions on the speed loop ports
module esr_speed_loop_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ecu_rx_msg,
    input wire logic        can_bus_off,
    input wire logic        can_err_passive,
    input wire logic        can_err_active,
    input wire logic [15:0] ecu_fault_in,
    input wire logic        link_loss_alarm,
    input wire logic        bus_off_alarm,
    input wire logic        bus_off_flag,
    input wire logic        error_passive_flag,
    input wire logic        error_active_flag,
    input wire logic        active_no_rx_flag,
    input wire logic [15:0] ecu_anomaly,
    input wire logic        can_tx_enable,
    input wire logic        ecu_cmd_enable,
    input wire logic        speed_cmd_enable,
    input wire logic        j1939_generic,
    input wire logic [15:0] cmd_pct
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_busoff;
        can_bus_off && j1939_generic |=> bus_off_alarm;
    endproperty
    a_busoff: assert property (p_busoff)
        else $error("no bus-off alarm");
    property p_no_busoff;
        !can_bus_off |=> !bus_off_alarm;
    endproperty
    a_no_busoff: assert property (p_no_busoff)
        else $error("stray bus-off alarm");
    property p_flags;
        bus_off_flag == $past(can_bus_off)
            && error_passive_flag == $past(can_err_passive)
            && error_active_flag == $past(can_err_active);
    endproperty
    a_flags: assert property (p_flags)
        else $error("can flags wrong");
    property p_no_rx;
        active_no_rx_flag |-> $past(can_err_active);
    endproperty
    a_no_rx: assert property (p_no_rx)
        else $error("stray no-rx flag");
    property p_link_clr;
        ecu_rx_msg |=> !link_loss_alarm;
    endproperty
    a_link_clr: assert property (p_link_clr)
        else $error("stray link-loss alarm");
    property p_tx;
        speed_cmd_enable |-> ecu_cmd_enable && can_tx_enable;
    endproperty
    a_tx: assert property (p_tx)
        else $error("speed cmd alone");
    property p_anom;
        (ecu_anomaly & ~$past(ecu_fault_in)) == 16'h0000;
    endproperty
    a_anom: assert property (p_anom)
        else $error("stray anomaly");
    property p_clamp;
        cmd_pct <= 16'h2710;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("cmd over full");
endmodule
bind esr_speed_loop esr_speed_loop_checker u_chk (.*);

// [sim/tb_esr_speed_loop.sv]
// bench for the speed regulation loop
module tb_esr_speed_loop;
    timeunit 1ns;
    timeprecision 1ps;
    import esr_pkg::*;
    localparam logic [6:0] MODES [6] = '{7'h00, 7'h01, 7'h02, 7'h5A,
                                         7'h5B, 7'h63};
    logic        pclk = 1'b0, presetn = 1'b0, talk = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, ecu_rx_msg, can_bus_off;
    logic        can_err_passive, can_err_active;
    logic [15:0] ecu_specific_in = 16'h0, ecu_fault_in = 16'h0;
    logic        engine_running = 1'b0, idle_cycle = 1'b0;
    logic        analog_sp_valid = 1'b0, load_breaker = 1'b0;
    logic [15:0] dc_voltage = 16'h0, analog_sp = 16'h0;
    logic [1:0]  can_state = 2'h0;
    logic        link_loss_alarm, bus_off_alarm, bus_off_flag;
    logic        error_passive_flag, error_active_flag, active_no_rx_flag;
    logic [3:0]  link_loss_type;
    logic [15:0] ecu_specific_flags, ecu_anomaly, speed_request_rpm;
    logic [15:0] cmd_pct, last_rpm;
    logic        can_tx_enable, on_demand_enable, ecu_cmd_enable;
    logic        speed_cmd_enable, j1939_generic, use_ecu_profile;
    int          n_fail = 0, n_checks = 0;
    esr_speed_loop #(.SEC_CYCLES(100), .LOOP_CYCLES(10)) dut_u (
        .*, .engine_start_stop(1'b0), .clutch_engaged(1'b0),
        .other_quantity(16'h0000));
    esr_ecu_model ecu_u (.*);
    always #4 pclk = ~pclk;
    task automatic check(input string nm, input logic [31:0] s, x);
        n_checks++;
        if (s !== x)
        begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", nm, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [7:0] ad(input logic [4:0] i);
        return {1'b0, i, 2'b00};
    endfunction
    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, ad(i), {16'h0000, d}, r, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, {r[31:1], r[0] ^ e ^ xe}, x);
    endtask
    task automatic pct(input string nm, input logic [15:0] x);
        repeat (30) @(posedge pclk);
        check(nm, {16'h0, cmd_pct}, {16'h0, x});
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd("ramp", ad(IDX_RAMP), 32'h64, 1'b0);
        rd("gain_p", ad(IDX_GAIN_P), 32'h64, 1'b0);
        rd("gain_i", ad(IDX_GAIN_I), 32'h64, 1'b0);
        rd("unmapped", 8'h5C, 32'h0, 1'b1);
        apb(1'b1, ad(IDX_STATUS), 32'h7F, r, e);
        check("ro_write", {31'h0, e}, 32'h1);
        $display("test regs done");
    endtask
    task automatic t_tx;
        logic [6:0] m;
        wr(IDX_ECU_TYPE, 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            m = MODES[i];
            wr(IDX_TX_MODE, {9'h0, m});
            @(posedge pclk);
            check("tx_mode", {28'h0, can_tx_enable, on_demand_enable,
                  ecu_cmd_enable, speed_cmd_enable}, {28'h0, m != 0, m != 0,
                  m >= 2 && m <= 99, m >= 91 && m <= 99});
        end
        check("generic", {31'h0, j1939_generic}, 32'h1);
        wr(IDX_ECU_TYPE, 16'h012C);
        @(posedge pclk);
        check("profile", {30'h0, use_ecu_profile, j1939_generic}, 32'h2);
        wr(IDX_ECU_TYPE, 16'h0001);
        $display("test tx done");
    endtask
    task automatic t_can;
        wr(IDX_FAULT_MASK, 16'h00FF);
        ecu_fault_in <= 16'h0F0F;
        ecu_specific_in <= 16'hA5C3;
        can_state <= 2'h2;
        repeat (3) @(posedge pclk);
        check("bus_off", {29'h0, bus_off_alarm, bus_off_flag,
              error_active_flag}, 32'h6);
        check("anomaly", {16'h0, ecu_anomaly}, 32'h0F00);
        check("specific", {16'h0, ecu_specific_flags}, 32'hA5C3);
        can_state <= 2'h1;
        repeat (3) @(posedge pclk);
        check("passive", {30'h0, bus_off_alarm, error_passive_flag},
              32'h1);
        wr(IDX_ECU_TYPE, 16'h0000);
        can_state <= 2'h2;
        repeat (3) @(posedge pclk);
        check("no_ecu", {30'h0, bus_off_alarm, bus_off_flag}, 32'h1);
        can_state <= 2'h0;
        wr(IDX_ECU_TYPE, 16'h0001);
        $display("test can done");
    endtask
    task automatic t_link;
        wr(IDX_LINK_TYPE, 16'h0005);
        wr(IDX_LINK_TMO, 16'h0002);
        talk <= 1'b0;
        repeat (160) @(posedge pclk);
        check("link_early", {31'h0, link_loss_alarm}, 32'h0);
        repeat (50) @(posedge pclk);
        check("link_loss", {27'h0, link_loss_alarm, link_loss_type},
              32'h15);
        check("no_rx", {31'h0, active_no_rx_flag}, 32'h1);
        talk <= 1'b1;
        repeat (40) @(posedge pclk);
        check("link_back", {30'h0, link_loss_alarm, active_no_rx_flag},
              32'h0);
        wr(IDX_LINK_TMO, 16'h0000);
        talk <= 1'b0;
        repeat (300) @(posedge pclk);
        check("link_off", {31'h0, link_loss_alarm}, 32'h0);
        talk <= 1'b1;
        $display("test link done");
    endtask
    task automatic t_map;
        wr(IDX_ZERO_SPD, 16'h03E8);
        wr(IDX_FULL_SPD, 16'h0BB8);
        wr(IDX_OFFSET, 16'h09C4);
        pct("offset", 16'h09C4);
        check("rpm", {16'h0, speed_request_rpm}, 32'h05DC);
        check("ecu_rpm", {16'h0, last_rpm}, 32'h05DC);
        wr(IDX_ZERO_SPD, 16'h0BB8);
        wr(IDX_FULL_SPD, 16'h03E8);
        repeat (3) @(posedge pclk);
        check("rpm_inv", {16'h0, speed_request_rpm}, 32'h09C4);
        wr(IDX_IDLE_SPD, 16'h0320);
        idle_cycle <= 1'b1;
        repeat (3) @(posedge pclk);
        check("idle", {16'h0, speed_request_rpm}, 32'h0320);
        idle_cycle <= 1'b0;
        wr(IDX_ZERO_SPD, 16'h03E8);
        wr(IDX_FULL_SPD, 16'h0BB8);
        $display("test map done");
    endtask
    task automatic t_loop;
        wr(IDX_RATED, 16'h03E8);
        wr(IDX_RAMP, 16'h0000);
        wr(IDX_GAIN_P, 16'h03E8);
        wr(IDX_GAIN_I, 16'h0000);
        wr(IDX_LOOP_DLY, 16'h0001);
        wr(IDX_DEAD_BAND, 16'h03E9);
        dc_voltage <= 16'h0384;
        engine_running <= 1'b1;
        repeat (220) @(posedge pclk);
        pct("dead_band", 16'h09C4);
        wr(IDX_DEAD_BAND, 16'h0000);
        pct("volt_low", 16'h0DAC);
        check("volt_rpm", {16'h0, speed_request_rpm}, 32'h06A4);
        wr(IDX_LOOP_OPT, 16'h0001);
        pct("invert", 16'h05DC);
        wr(IDX_LOOP_OPT, 16'h0000);
        analog_sp <= 16'h0320;
        analog_sp_valid <= 1'b1;
        pct("analog", 16'h05DC);
        dc_voltage <= 16'h0000;
        wr(IDX_NOMINAL, 16'h07D0);
        pct("nominal", 16'h1964);
        wr(IDX_NOMINAL, 16'h0000);
        pct("clamp", 16'h2710);
        wr(IDX_LOOP_OPT, 16'h0002);
        pct("no_load", 16'h09C4);
        load_breaker <= 1'b1;
        pct("load_on", 16'h2710);
        wr(IDX_GAIN_P, 16'h0000);
        pct("no_gain", 16'h09C4);
        engine_running <= 1'b0;
        $display("test loop done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_tx();
        t_can();
        t_link();
        t_map();
        t_loop();
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
endmodule
